// [rpec_pkg.sv]
// package for the radio power enable and reset control block
//
// How it works
// - in shutdown every output of the device floats and most input receivers are switched off.
// - leaving shutdown is a fresh power-up, so no state from before it survives.
// - a high wlan power enable turns the regulators on and lets the wlan section out of reset.
// - a low wlan power enable keeps the wlan section in reset whatever bluetooth asks.
// - the regulator enable is the or of the two power enables.
// - with both power enables low every regulator is off and the part is powered down.
// - each power enable pin has a pull-down that is on after reset and software may turn off.
// - the reference clock input buffer is on only while active, and off while asleep or in shutdown.
// - the bluetooth power enable likewise holds or releases the bluetooth section reset.
package rpec_pkg;
  // -------------------------------------------------------------
  // synchroniser and state
  // -------------------------------------------------------------
  localparam int unsigned RPEC_SYNC_STAGES = 2;
  localparam logic        RPEC_PULL_RESET  = 1'h1;
  typedef enum logic [1:0] {
    RPEC_OFF,
    RPEC_ACTIVE,
    RPEC_SLEEP
  } rpec_state_e;
  typedef struct packed {
    logic wlan;
    logic bluetooth;
  } rpec_enable_s;
endpackage : rpec_pkg

// [rpec_sync.sv]
// two-flop level synchroniser for the power enable pins
`timescale 1ns/1ps
`default_nettype none
module rpec_sync
  import rpec_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= meta_next;
      o_sync   <= sync_next;
    end
  end
endmodule : rpec_sync
`default_nettype wire

// [rpec_top.sv]
// power enable, section reset and shutdown control
`timescale 1ns/1ps
`default_nettype none
module rpec_top
  import rpec_pkg::*;
(
  // always-on clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // power enable pins from the host
  input  wire logic i_wlan_power_enable,
  input  wire logic i_bluetooth_power_enable,
  // settings from the internal software
  input  wire logic i_pull_down_disable,
  input  wire logic i_sleep_request,
  // power and reset controls
  output var  logic o_regulator_enable,
  output var  logic o_wlan_reset_n,
  output var  logic o_bluetooth_reset_n,
  output var  logic o_pull_down_enable,
  output var  logic o_ref_clock_buffer_enable,
  output var  logic o_output_enable,
  output var  logic o_input_enable,
  output var  logic o_core_clear
);
  // -------------------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------------------
  rpec_enable_s pins_async;
  rpec_enable_s pins_sync;

  assign pins_async = '{wlan: i_wlan_power_enable, bluetooth: i_bluetooth_power_enable};

  rpec_sync #(.WIDTH(2)) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (pins_async),
    .o_sync  (pins_sync)
  );

  // -------------------------------------------------------------
  // power state
  // -------------------------------------------------------------
  rpec_state_e state_reg;
  rpec_state_e state_next;
  logic        any_on;
  logic        pull_next;
  logic        prev_off_reg;
  logic        prev_off_next;
  logic        regulator_next;
  logic        wlan_reset_n_next;
  logic        bluetooth_reset_n_next;
  logic        buffer_next;
  logic        io_enable_next;
  logic        core_clear_next;

  assign any_on = pins_sync.wlan | pins_sync.bluetooth;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPEC_OFF: begin
        if (any_on) begin
          state_next = RPEC_ACTIVE;
        end
      end
      RPEC_ACTIVE: begin
        if (!any_on) begin
          state_next = RPEC_OFF;
        end else if (i_sleep_request) begin
          state_next = RPEC_SLEEP;
        end
      end
      default: begin
        if (!any_on) begin
          state_next = RPEC_OFF;
        end else if (!i_sleep_request) begin
          state_next = RPEC_ACTIVE;
        end
      end
    endcase
  end

  // the pull-down setting lives in the powered domain and is lost in shutdown
  always_comb begin
    pull_next = ~i_pull_down_disable;
    if (state_reg == RPEC_OFF) begin
      pull_next = RPEC_PULL_RESET;
    end
  end

  // -------------------------------------------------------------
  // output decode
  // -------------------------------------------------------------
  // the regulator, buffer and io enables are decoded from the next state, so they change on the same edge as the state
  // core clear overlaps the first powered cycle so the rest of the chip leaves reset cleanly
  always_comb begin
    prev_off_next          = (state_next == RPEC_OFF);
    regulator_next         = (state_next != RPEC_OFF);
    wlan_reset_n_next      = pins_sync.wlan;
    bluetooth_reset_n_next = pins_sync.bluetooth;
    buffer_next            = (state_next == RPEC_ACTIVE);
    io_enable_next         = (state_next != RPEC_OFF);
    core_clear_next        = prev_off_next | prev_off_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg                 <= RPEC_OFF;
      prev_off_reg              <= 1'h1;
      o_regulator_enable        <= 1'h0;
      o_wlan_reset_n            <= 1'h0;
      o_bluetooth_reset_n       <= 1'h0;
      o_pull_down_enable        <= RPEC_PULL_RESET;
      o_ref_clock_buffer_enable <= 1'h0;
      o_output_enable           <= 1'h0;
      o_input_enable            <= 1'h0;
      o_core_clear              <= 1'h1;
    end else begin
      state_reg                 <= state_next;
      prev_off_reg              <= prev_off_next;
      o_regulator_enable        <= regulator_next;
      o_wlan_reset_n            <= wlan_reset_n_next;
      o_bluetooth_reset_n       <= bluetooth_reset_n_next;
      o_pull_down_enable        <= pull_next;
      o_ref_clock_buffer_enable <= buffer_next;
      o_output_enable           <= io_enable_next;
      o_input_enable            <= io_enable_next;
      o_core_clear              <= core_clear_next;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence both_low_s;
    !pins_sync.wlan && !pins_sync.bluetooth;
  endsequence

  sequence any_on_s;
    pins_sync.wlan || pins_sync.bluetooth;
  endsequence

  sequence bt_only_s;
    !pins_sync.wlan && pins_sync.bluetooth;
  endsequence

  sequence powered_s;
    state_reg != RPEC_OFF;
  endsequence

  sequence sleep_s;
    state_reg == RPEC_ACTIVE && any_on && i_sleep_request;
  endsequence

  sequence wake_s;
    state_reg == RPEC_SLEEP && any_on && !i_sleep_request;
  endsequence

  sequence power_up_s;
    $rose(o_regulator_enable) ##1 o_regulator_enable;
  endsequence

  sequence wlan_rise_held_s;
    $rose(i_wlan_power_enable) ##1 i_wlan_power_enable[*2];
  endsequence

  wlan_reset_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !pins_sync.wlan |=> !o_wlan_reset_n) else $error("wlan left reset while enable low");
  wlan_release_a: assert property (@(posedge i_clock) disable iff (i_reset)
    pins_sync.wlan |=> o_wlan_reset_n && o_regulator_enable) else $error("wlan not released");
  bt_reset_a: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 o_bluetooth_reset_n == $past(pins_sync.bluetooth)) else $error("bluetooth reset wrong");
  reg_or_a: assert property (@(posedge i_clock) disable iff (i_reset)
    pins_sync.bluetooth |=> o_regulator_enable) else $error("regulator off with bt enable");
  power_down_a: assert property (@(posedge i_clock) disable iff (i_reset)
    both_low_s |=> !o_regulator_enable && !o_ref_clock_buffer_enable) else $error("not off");
  io_float_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_regulator_enable |-> !o_output_enable && !o_input_enable) else $error("io on in shutdown");
  pull_default_a: assert property (@(posedge i_clock) disable iff (i_reset)
    both_low_s ##1 both_low_s |=> o_pull_down_enable) else $error("pull-down not restored");
  buffer_sleep_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == RPEC_SLEEP |-> !o_ref_clock_buffer_enable) else $error("buffer on in sleep");
  fresh_start_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_regulator_enable) |-> o_core_clear) else $error("core not cleared at power-up");
  sync_delay_a: assert property (@(posedge i_clock) disable iff (i_reset)
    wlan_rise_held_s |=> o_wlan_reset_n)
    else $error("wlan enable not seen after sync");

  // -------------------------------------------------------------
  // shutdown, setting and start-up checks
  // -------------------------------------------------------------
  io_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
    both_low_s |=> !o_output_enable && !o_input_enable) else $error("io driven while off");

  io_on_a: assert property (@(posedge i_clock) disable iff (i_reset)
    any_on_s |=> o_output_enable && o_input_enable) else $error("io off while powered");

  wlan_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
    bt_only_s |=> !o_wlan_reset_n && o_regulator_enable)
    else $error("wlan released by bluetooth enable");

  bt_release_a: assert property (@(posedge i_clock) disable iff (i_reset)
    bt_only_s |=> o_bluetooth_reset_n && o_output_enable)
    else $error("bluetooth not released on its own enable");

  // the setting takes hold one cycle after power-up, since it looks at the current state
  pull_setting_a: assert property (@(posedge i_clock) disable iff (i_reset)
    powered_s |=> o_pull_down_enable == !$past(i_pull_down_disable))
    else $error("pull-down setting ignored");

  buffer_enter_a: assert property (@(posedge i_clock) disable iff (i_reset)
    sleep_s |=> !o_ref_clock_buffer_enable) else $error("buffer on after sleep entry");

  buffer_wake_a: assert property (@(posedge i_clock) disable iff (i_reset)
    wake_s |=> o_ref_clock_buffer_enable) else $error("buffer off after wake");

  clear_release_a: assert property (@(posedge i_clock) disable iff (i_reset)
    power_up_s |-> !o_core_clear) else $error("core clear held after power-up");

  clear_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
    both_low_s |=> o_core_clear) else $error("core not cleared while off");

  // a single flop here would let a pin glitch reach the section reset unfiltered
  sync_latency_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(i_wlan_power_enable) |=> !o_wlan_reset_n) else $error("wlan enable bypassed sync");

  // reset has to look exactly like a power-down, whatever state came before it
  reset_state_a: assert property (@(posedge i_clock)
    i_reset |=> !o_regulator_enable && !o_wlan_reset_n && !o_bluetooth_reset_n
      && o_pull_down_enable && o_core_clear) else $error("outputs not at power-up level");
endmodule : rpec_top
`default_nettype wire

// [rpec_host.sv]
// host-side model that drives or releases the two power enable pins
`timescale 1ns/1ps
`default_nettype none
module rpec_host (
  // clock and pin control
  input  wire logic       i_clock,
  input  wire logic       i_drive,
  input  wire logic       i_pull,
  input  wire logic [1:0] i_level,
  // pins {wlan, bluetooth}
  output var  logic [1:0] o_pin
);
  logic [1:0] last_reg = 2'h0;
  // an external reference in place of a crystal is offered only on an sdio or hsic link
  localparam int unsigned REF_CLOCK_KHZ = 52000;
  always_ff @(posedge i_clock) begin
    last_reg <= o_pin;
  end
  // a released pin sits low under the pull-down, else drifts away from its last level
  always_comb begin
    o_pin = i_drive ? i_level : (i_pull ? 2'h0 : ~last_reg);
  end
endmodule : rpec_host
`default_nettype wire

// [tb.sv]
// self-checking bench for the power enable and reset control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rpec_pkg::*;
  typedef struct {int due; logic [7:0] mask; logic [7:0] vec;} rpec_note_s;
  logic clk = 1'h0, rst = 1'h1, drv = 1'h1, pdd = 1'h0, slp = 1'h0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] pin;
  wire logic [7:0] seen;
  int cyc = 0, num_errors = 0, samples_checked = 0;
  rpec_note_s q[$];
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  rpec_host u_rpec_host (.i_clock(clk), .i_drive(drv), .i_pull(seen[1]), .i_level(lvl),
    .o_pin(pin));
  rpec_top u_rpec_top (.i_clock(clk), .i_reset(rst), .i_wlan_power_enable(pin[1]),
    .i_bluetooth_power_enable(pin[0]), .i_pull_down_disable(pdd), .i_sleep_request(slp),
    .o_regulator_enable(seen[7]), .o_wlan_reset_n(seen[6]), .o_bluetooth_reset_n(seen[5]),
    .o_ref_clock_buffer_enable(seen[4]), .o_output_enable(seen[3]), .o_input_enable(seen[2]),
    .o_pull_down_enable(seen[1]), .o_core_clear(seen[0]));
  // settled outputs {regulator, wlan_rst_n, bt_rst_n, buffer, oe, ie, pull, clear}
  function automatic logic [7:0] exp_f(input logic [1:0] p, input logic d, input logic s);
    logic on;
    on = |p;
    return {on, p[1], p[0], on & ~s, on, on, on ? ~d : 1'h1, ~on};
  endfunction : exp_f
  task automatic check(input string name, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      check("outputs", seen & q[0].mask, q[0].vec & q[0].mask);
      void'(q.pop_front());
    end
  end
  always @(posedge clk) begin
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] prev, nxt;
    logic d;
    void'($urandom(32'h5F67));
    prev = exp_f(2'h0, 1'h0, 1'h0);
    q.push_back('{3, 8'hFF, prev});
    repeat (6) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      d = ($urandom % 4) != 0;
      // a pin is released only with its pull-down on, so it never floats
      if (!d) begin
        pdd = 1'h0;
        @(negedge clk);
      end
      drv = d;
      lvl = 2'($urandom);
      pdd = d ? 1'($urandom) : 1'h0;
      slp = 1'($urandom);
      nxt = exp_f(d ? lvl : 2'h0, pdd, slp);
      q.push_back('{cyc + 2, 8'hE0, prev});
      q.push_back('{cyc + 3, 8'hE0, nxt});
      q.push_back('{cyc + 5, 8'hFF, nxt});
      prev = nxt;
      repeat (4 + $urandom % 3) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    check("notes left", 8'(q.size()), 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
